// file: ip_code_priority_map_priority_map_params.svh
// Offsets, reset values and field layout of the code priority map registers
`ifndef IP_CODE_PRIORITY_MAP_PRIORITY_MAP_PARAMS_SVH
`define IP_CODE_PRIORITY_MAP_PRIORITY_MAP_PARAMS_SVH

`define CPM_ADDR_W 8
`define CPM_DATA_W 8
`define CPM_BASE_OFFSET 8'h90
`define CPM_LAST_OFFSET 8'h9c
`define CPM_NUM_REGS 13
`define CPM_REG_RESET 8'h00
`define CPM_ENTRY_W 2
`define CPM_ENTRIES_PER_REG 4
`define CPM_CODE_W 6
`define CPM_NUM_CODES 64
`define CPM_CODE_MSB 7
`define CPM_CODE_LSB 2
`define CPM_UNMAPPED_RDATA 8'h00
`define CPM_IDX_W 4
`define CPM_OFS_MAP_00_03 8'h90
`define CPM_OFS_MAP_04_07 8'h91
`define CPM_OFS_MAP_08_0B 8'h92
`define CPM_OFS_MAP_0C_0F 8'h93
`define CPM_OFS_MAP_10_13 8'h94
`define CPM_OFS_MAP_14_17 8'h95
`define CPM_OFS_MAP_18_1B 8'h96
`define CPM_OFS_MAP_1C_1F 8'h97
`define CPM_OFS_MAP_20_23 8'h98
`define CPM_OFS_MAP_24_27 8'h99
`define CPM_OFS_MAP_28_2B 8'h9a
`define CPM_OFS_MAP_2C_2F 8'h9b
`define CPM_OFS_MAP_30_33 8'h9c

`endif

// file: ip_code_priority_map_priority_map_pkg.sv
// Types shared by the code priority map block
package ip_code_priority_map_priority_map_pkg;

    typedef logic [1:0] prio_t;

    // Header summary from the ingress parser
    typedef struct packed {
        logic is_ipv4;
        logic is_ipv6;
        logic [7:0] tos_byte;
    } frame_hdr_s;

    // Classification result toward the queue logic
    typedef struct packed {
        logic ip_hit;
        prio_t prio;
    } prio_result_s;

endpackage : ip_code_priority_map_priority_map_pkg

// file: ip_code_priority_map_priority_map.sv
// Code priority map: register bank plus ingress classification
//
// How it works
// - Code is bits 7:2 of the type-of-service or traffic-class byte.
// - Code is fully decoded into 64 one-hot selections, one entry each.
// - For IPv4/IPv6 frames priority equals the selected two-bit entry (else 00); code n uses bits 2n+1:2n.
// - Lowest register holds codes 0x00..0x03, code 0x00 in bits 1:0.
// - Each next offset holds next four codes; 0x91 covers 0x04..0x07.
// - Register at 0x9c holds codes 0x30..0x33, 0x33 in bits 7:6.
// - Every entry is read/write and resets to 00.
// - One table serves both IPv4 and IPv6 frames.
//
// Register map, one byte each, lowest code in bits 1:0:
//   0x90 code_priority_map_00_03   codes 0x00..0x03
//   0x91 code_priority_map_04_07   codes 0x04..0x07
//   0x92 code_priority_map_08_0b   codes 0x08..0x0b
//   0x93 code_priority_map_0c_0f   codes 0x0c..0x0f
//   0x94 code_priority_map_10_13   codes 0x10..0x13
//   0x95 code_priority_map_14_17   codes 0x14..0x17
//   0x96 code_priority_map_18_1b   codes 0x18..0x1b
//   0x97 code_priority_map_1c_1f   codes 0x1c..0x1f
//   0x98 code_priority_map_20_23   codes 0x20..0x23
//   0x99 code_priority_map_24_27   codes 0x24..0x27
//   0x9a code_priority_map_28_2b   codes 0x28..0x2b
//   0x9b code_priority_map_2c_2f   codes 0x2c..0x2f
//   0x9c code_priority_map_30_33   codes 0x30..0x33
// Codes 0x34..0x3f have no register here and classify as priority 00.
// Offsets outside 0x90..0x9c ignore writes and read back as 0x00.
//
// Timing: a read answers one cycle after its strobe; a header gives its
// result one cycle after its valid. A map write counts for headers
// sampled from the edge after the write edge on; a read in the same
// cycle as a write to that register still returns the old byte.
`timescale 1ns/100ps
`include "ip_code_priority_map_priority_map_params.svh"

module ip_code_priority_map_priority_map #(
    parameter int NUM_REGS = `CPM_NUM_REGS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Switch register interface
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [`CPM_ADDR_W-1:0] reg_addr,
    input wire logic [`CPM_DATA_W-1:0] reg_wdata,
    output logic [`CPM_DATA_W-1:0] reg_rdata_ff,
    output logic reg_rvalid_ff,
    // Ingress header in
    input wire logic hdr_valid,
    input ip_code_priority_map_priority_map_pkg::frame_hdr_s hdr,
    // Priority result out
    output logic res_valid_ff,
    output ip_code_priority_map_priority_map_pkg::prio_result_s res_ff
);

    // Whole table width, and the code width used to size decode constants
    localparam int TABLE_W = `CPM_NUM_CODES * `CPM_ENTRY_W;
    localparam int CODE_W = `CPM_CODE_W;

    // Map storage and register decode
    logic [`CPM_DATA_W-1:0] map_ff [NUM_REGS];
    logic [`CPM_IDX_W-1:0] reg_index;
    logic dec_hit;
    logic addr_hit;

    // Classification path
    logic [TABLE_W-1:0] table_flat;
    logic [`CPM_CODE_W-1:0] code;
    logic [`CPM_NUM_CODES-1:0] code_sel;
    logic [`CPM_NUM_CODES-1:0] sel_lo;
    logic [`CPM_NUM_CODES-1:0] sel_hi;
    logic is_ip;
    ip_code_priority_map_priority_map_pkg::prio_t nxt_prio;

    // Offset decode: each register's offset is matched on its own, so the
    // map may grow or move without shifting the others. Index width caps
    // NUM_REGS at 16; a smaller NUM_REGS leaves upper offsets unmapped.
    always_comb begin
        dec_hit = 1'b0;
        reg_index = 4'h0;
        case (reg_addr)
            `CPM_OFS_MAP_00_03: begin
                dec_hit = 1'b1;
                reg_index = 4'h0;
            end
            `CPM_OFS_MAP_04_07: begin
                dec_hit = 1'b1;
                reg_index = 4'h1;
            end
            `CPM_OFS_MAP_08_0B: begin
                dec_hit = 1'b1;
                reg_index = 4'h2;
            end
            `CPM_OFS_MAP_0C_0F: begin
                dec_hit = 1'b1;
                reg_index = 4'h3;
            end
            `CPM_OFS_MAP_10_13: begin
                dec_hit = 1'b1;
                reg_index = 4'h4;
            end
            `CPM_OFS_MAP_14_17: begin
                dec_hit = 1'b1;
                reg_index = 4'h5;
            end
            `CPM_OFS_MAP_18_1B: begin
                dec_hit = 1'b1;
                reg_index = 4'h6;
            end
            `CPM_OFS_MAP_1C_1F: begin
                dec_hit = 1'b1;
                reg_index = 4'h7;
            end
            `CPM_OFS_MAP_20_23: begin
                dec_hit = 1'b1;
                reg_index = 4'h8;
            end
            `CPM_OFS_MAP_24_27: begin
                dec_hit = 1'b1;
                reg_index = 4'h9;
            end
            `CPM_OFS_MAP_28_2B: begin
                dec_hit = 1'b1;
                reg_index = 4'ha;
            end
            `CPM_OFS_MAP_2C_2F: begin
                dec_hit = 1'b1;
                reg_index = 4'hb;
            end
            `CPM_OFS_MAP_30_33: begin
                dec_hit = 1'b1;
                reg_index = 4'hc;
            end
            default: begin
                dec_hit = 1'b0;
                reg_index = 4'h0;
            end
        endcase
    end

    // Unbuilt registers behave exactly like unmapped offsets
    assign addr_hit = dec_hit && (int'(reg_index) < NUM_REGS);

    // Map registers: byte-wide read/write, cleared by reset
    // Whole-byte writes: software sets all four entries of a register at once
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                map_ff[i] <= `CPM_REG_RESET;
            end
        end else if (reg_wr && addr_hit) begin
            map_ff[reg_index] <= reg_wdata;
        end
    end

    // Read strobe echo; marks the cycle in which the read byte is fresh
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rvalid_ff <= 1'b0;
        end else begin
            reg_rvalid_ff <= reg_rd;
        end
    end

    // Read data, captured one cycle after the strobe and held until the next
    // read; unmapped offsets read zero so software sees no stale byte
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata_ff <= `CPM_REG_RESET;
        end else if (reg_rd) begin
            reg_rdata_ff <= addr_hit ? map_ff[reg_index] : `CPM_UNMAPPED_RDATA;
        end
    end

    // Flatten registers into one table, lowest code in lowest bits
    always_comb begin
        table_flat = '0;
        for (int r = 0; r < NUM_REGS; r++) begin
            table_flat[r*`CPM_DATA_W +: `CPM_DATA_W] = map_ff[r];
        end
    end

    // Code extraction and full one-hot decode
    assign code = hdr.tos_byte[`CPM_CODE_MSB:`CPM_CODE_LSB];
    assign is_ip = hdr.is_ipv4 | hdr.is_ipv6;

    // Each selection line gates exactly its own entry; the AND-OR tree
    // avoids a wide mux and keeps the decode visible to checkers
    genvar g;
    generate
        for (g = 0; g < `CPM_NUM_CODES; g++) begin : g_decode
            assign code_sel[g] = (code == CODE_W'(g));
            assign sel_lo[g] = code_sel[g] & table_flat[g*`CPM_ENTRY_W];
            assign sel_hi[g] = code_sel[g] & table_flat[g*`CPM_ENTRY_W+1];
        end
    endgenerate

    assign nxt_prio = {|sel_hi, |sel_lo};

    // Result valid: a one-cycle echo of the header valid
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            res_valid_ff <= 1'b0;
        end else begin
            res_valid_ff <= hdr_valid;
        end
    end

    // Result fields, held until the next header so late readers still see them;
    // codes above the table give priority 00
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            res_ff <= '0;
        end else if (hdr_valid) begin
            res_ff.ip_hit <= is_ip;
            res_ff.prio <= is_ip ? nxt_prio : 2'h0;
        end
    end

endmodule : ip_code_priority_map_priority_map

// file: ip_code_priority_map_priority_map_asserts.sv
// Port checker for the code priority map
`timescale 1ns/100ps
module cpm_chk (
    input wire logic clk, sys_rst, reg_rd, reg_rvalid_ff, hdr_valid, res_valid_ff,
    input wire logic [7:0] reg_rdata_ff,
    input ip_code_priority_map_priority_map_pkg::frame_hdr_s hdr,
    input ip_code_priority_map_priority_map_pkg::prio_result_s res_ff
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_rd_ack: assert property (reg_rd |=> reg_rvalid_ff) else $error("no ack");
    a_rd_idle: assert property (!reg_rd |=> !reg_rvalid_ff) else $error("stray ack");
    a_rd_hold: assert property (!reg_rd |=> $stable(reg_rdata_ff)) else $error("rdata");
    a_res_ack: assert property (hdr_valid |=> res_valid_ff) else $error("no result");
    a_res_hold: assert property (!hdr_valid |=> $stable(res_ff)) else $error("moved");
    a_res_cause: assert property (res_valid_ff |-> $past(hdr_valid)) else $error("stray");
    a_ip_hit: assert property (hdr_valid && (hdr.is_ipv4 || hdr.is_ipv6) |=> res_ff.ip_hit)
        else $error("no hit");
    a_non_ip: assert property (hdr_valid && !hdr.is_ipv4 && !hdr.is_ipv6 |=> !res_ff)
        else $error("non ip hit");
    c_rd: cover property (reg_rd ##1 reg_rvalid_ff);
    c_v6: cover property (hdr_valid && hdr.is_ipv6);
    c_none: cover property (hdr_valid && !hdr.is_ipv4 && !hdr.is_ipv6);
endmodule : cpm_chk
bind ip_code_priority_map_priority_map cpm_chk u (.clk(clk), .sys_rst(sys_rst), .reg_rd(reg_rd),
    .reg_rvalid_ff(reg_rvalid_ff), .hdr_valid(hdr_valid), .res_valid_ff(res_valid_ff),
    .reg_rdata_ff(reg_rdata_ff), .hdr(hdr), .res_ff(res_ff));

// file: hdr_src.sv
// Ingress parser model: one header summary per call
`timescale 1ns/100ps
module hdr_src (
    input wire logic clk,
    output logic hdr_valid,
    output ip_code_priority_map_priority_map_pkg::frame_hdr_s hdr
);
    initial {hdr_valid, hdr} = 11'h000;
    // Byte is inverted once released, so a late sample cannot pass by luck
    task send(input logic [9:0] h);
        {hdr_valid, hdr} = {1'b1, h};
        @(posedge clk) #1 {hdr_valid, hdr} = {1'b0, h ^ 10'h0ff};
        @(posedge clk) #1;
    endtask : send
endmodule : hdr_src

// file: ip_code_priority_map_priority_map_tb_top.sv
// Bench for the code priority map
`timescale 1ns/100ps
module ip_code_priority_map_priority_map_tb_top;
    logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, hdr_valid;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata_ff;
    logic reg_rvalid_ff, res_valid_ff;
    ip_code_priority_map_priority_map_pkg::frame_hdr_s hdr;
    ip_code_priority_map_priority_map_pkg::prio_result_s res_ff;
    int failures = 0, check_count = 0, cyc = 0;
    ip_code_priority_map_priority_map dut (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
        .reg_rvalid_ff(reg_rvalid_ff), .hdr_valid(hdr_valid), .hdr(hdr),
        .res_valid_ff(res_valid_ff), .res_ff(res_ff));
    hdr_src src (.clk(clk), .hdr_valid(hdr_valid), .hdr(hdr));
    initial forever #2.5 clk = ~clk;
    // Hang guard: the run needs well under 500 cycles
    always @(posedge clk) if (++cyc == 2000) final_report(1);
    task chk(input logic [7:0] seen, exp);
        check_count++;
        failures += int'(seen !== exp);
        if (seen !== exp) $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
    endtask : chk
    // One strobe cycle, then one idle cycle so strobes never toggle twice at once
    task acc(input logic wr, input logic [7:0] a, w);
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {wr, !wr, a, w};
        @(posedge clk) #1 {reg_wr, reg_rd} = 2'h0;
        chk({7'h00, reg_rvalid_ff}, {7'h00, !wr});
        @(posedge clk) #1;
        chk({7'h00, reg_rvalid_ff}, 8'h00);
    endtask : acc
    // One header through the parser model; the valid pulse is seen while it stands
    task classify(input logic [9:0] h, input logic [7:0] exp);
        fork
            src.send(h);
            begin
                @(posedge clk) #1 chk({7'h00, res_valid_ff}, 8'h01);
            end
        join
        chk({5'h00, res_ff}, exp);
        chk({7'h00, res_valid_ff}, 8'h00);
    endtask : classify
    task final_report(input int late);
        failures += late;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : final_report
    // Distinct byte per register, then every code through the map
    initial begin
        repeat (20) @(posedge clk);
        #1 sys_rst = 1'b0;
        for (int r = 0; r < 14; r++) begin
            acc(1'b0, 8'h90 + 8'(r), 8'h00);
            chk(reg_rdata_ff, 8'h00);
            acc(1'b1, 8'h90 + 8'(r), 8'he4 ^ 8'(r * 17));
            acc(1'b0, 8'h90 + 8'(r), 8'h00);
            chk(reg_rdata_ff, r > 12 ? 8'h00 : 8'he4 ^ 8'(r * 17));
        end
        for (int c = 0; c < 65; c++) begin
            classify({c[0], !c[0] && c < 64, 6'(c), 2'(c)},
                c > 63 ? 8'h00 : {6'h01, c > 51 ? 2'h0 :
                2'((8'he4 ^ 8'(c / 4 * 17)) >> (2 * (c % 4)))});
        end
        // Mid-run reset must clear written entries, not only the read register
        sys_rst = 1'b1;
        repeat (2) @(posedge clk);
        #1 sys_rst = 1'b0;
        acc(1'b0, 8'h9c, 8'h00);
        chk(reg_rdata_ff, 8'h00);
        classify({2'h3, 8'hc4}, 8'h04);
        final_report(0);
    end
endmodule : ip_code_priority_map_priority_map_tb_top
